// *** rtl/ccd_counter_clock_divider.v ***
// Counter configured as a frequency divider with gate and direction control.
// Assumes all pins and config inputs are synchronous to ref_clk_i.
//
// Summary of operation
// RULE1: Output frequency is input frequency over divisor.
// RULE2: Gate mode 0 ignores gate, starts on command.
// RULE3: Gate mode 1 counts only while gate high.
// RULE4: Direction source selects software setting or pin.
// RULE5: Software direction 0 decrements, 1 increments.
// RULE6: Timebase zero uses pin edges, positive internal.
// RULE7: Load value is divisor counting down, 1 counting up; one period per pass.
// RULE8: Terminal count reloads and pulses output once.
`timescale 1ns/1ps
`include "ccd_defines.vh"

module ccd_counter_clock_divider #(
  parameter DIV_W = `CCD_DIV_W,
  parameter TB_W  = `CCD_TB_W
) (
  input  wire             ref_clk_i,
  input  wire             reset_i,
  input  wire             start_i,
  input  wire             stop_i,
  input  wire             gate_mode_i,
  input  wire             gate_i,
  input  wire             dir_source_i,
  input  wire             dir_soft_i,
  input  wire             direction_pin_i,
  input  wire [TB_W-1:0]  timebase_period_i,
  input  wire [DIV_W-1:0] divisor_i,
  input  wire             ext_count_clock_pin_i,
  output reg              counter_output_pin_o,
  output reg              running_o,
  output reg  [DIV_W-1:0] count_o
);

  // ****************************************
  // Local constants and state codes
  // ****************************************
  localparam [0:0]       ST_IDLE = `CCD_ST_IDLE;
  localparam [0:0]       ST_RUN  = `CCD_ST_RUN;
  localparam [DIV_W-1:0] ONE_DIV = {{(DIV_W-1){1'b0}}, 1'b1};
  localparam [DIV_W-1:0] ZERO_DV = {DIV_W{1'b0}};
  localparam [TB_W-1:0]  ONE_TB  = {{(TB_W-1){1'b0}}, 1'b1};
  localparam [TB_W-1:0]  ZERO_TB = {TB_W{1'b0}};

  // ****************************************
  // Decode helpers
  // ****************************************
  // First count of a pass; shared by start and reload so both agree.
  function [DIV_W-1:0] load_value;
    input             up;
    input [DIV_W-1:0] div;
    begin
      if (up) begin
        load_value = ONE_DIV;
      end else begin
        load_value = div;
      end
    end
  endfunction

  // Last count of a pass; compares rather than matches, so a
  // direction change mid-pass can never run past the end and wrap.
  function at_end;
    input             up;
    input [DIV_W-1:0] cnt;
    input [DIV_W-1:0] div;
    begin
      if (up) begin
        at_end = (cnt >= div);
      end else begin
        at_end = (cnt <= ONE_DIV);
      end
    end
  endfunction

  // ****************************************
  // Internal signals
  // ****************************************
  reg              pin_last;
  reg  [TB_W-1:0]  tb_cnt;
  reg  [TB_W-1:0]  next_tb_cnt;
  reg              use_pin;
  reg              pin_rise;
  reg              tb_tick;
  reg              src_edge;
  reg              gate_ok;
  reg              dir_up;
  reg              count_en;
  reg  [DIV_W-1:0] div_eff;
  reg              at_terminal;
  reg  [DIV_W-1:0] start_value;
  reg  [DIV_W-1:0] next_count;
  reg              next_pulse;
  reg              next_running;

  // ****************************************
  // Count source selection
  // ****************************************
  // Timebase input is the internal period in ref_clk_i cycles; zero selects pin.
  always @* begin
    use_pin  = (timebase_period_i == ZERO_TB);                                // [RULE6]
    pin_rise = ext_count_clock_pin_i & ~pin_last;
    tb_tick  = 1'b0;
    src_edge = 1'b0;
    if (use_pin) begin
      src_edge = pin_rise;                                                    // [RULE6]
    end else begin
      tb_tick  = (tb_cnt >= timebase_period_i - ONE_TB);
      src_edge = tb_tick;                                                     // [RULE6]
    end
  end

  // Timebase restarts on every tick and rests at zero in pin mode.
  always @* begin
    if (use_pin || tb_tick) begin
      next_tb_cnt = ZERO_TB;
    end else begin
      next_tb_cnt = tb_cnt + ONE_TB;
    end
  end

  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_last <= 1'b0;
      tb_cnt   <= ZERO_TB;
    end else begin
      pin_last <= ext_count_clock_pin_i;
      tb_cnt   <= next_tb_cnt;
    end
  end

  // ****************************************
  // Qualification and direction
  // ****************************************
  always @* begin
    if (gate_mode_i == `CCD_GATE_SOFT) begin
      gate_ok = 1'b1;                                                         // [RULE2]
    end else begin
      gate_ok = gate_i;                                                       // [RULE3]
    end
  end

  always @* begin
    if (dir_source_i == `CCD_DIRSRC_PIN) begin
      dir_up = direction_pin_i;                                               // [RULE4]
    end else begin
      dir_up = (dir_soft_i == `CCD_DIR_UP);                                   // [RULE5]
    end
  end

  // Zero divisor behaves as one so the counter never stalls on a bad value.
  always @* begin
    if (divisor_i == ZERO_DV) begin
      div_eff = ONE_DIV;
    end else begin
      div_eff = divisor_i;
    end
  end

  // Edges while idle or gated off are dropped, not held for later.
  always @* begin
    count_en    = running_o & gate_ok & src_edge;                             // [RULE2] [RULE3]
    at_terminal = at_end(dir_up, count_o, div_eff);
    start_value = load_value(dir_up, div_eff);                                // [RULE7]
  end

  // ****************************************
  // Next count and pulse
  // ****************************************
  // Down runs divisor..1, up runs 1..divisor: divisor edges per pulse.
  always @* begin
    next_count = count_o;
    next_pulse = 1'b0;
    if (count_en) begin
      if (at_terminal) begin
        next_count = start_value;                                             // [RULE8] [RULE7]
        next_pulse = 1'b1;                                                    // [RULE8] [RULE1]
      end else if (dir_up) begin
        next_count = count_o + ONE_DIV;                                       // [RULE5]
      end else begin
        next_count = count_o - ONE_DIV;                                       // [RULE7]
      end
    end
  end

  // ****************************************
  // Run state
  // ****************************************
  // Start is ignored while running; an edge in the stop cycle still counts.
  always @* begin
    next_running = running_o;
    case (running_o)
      ST_IDLE: begin
        if (start_i) begin
          next_running = ST_RUN;                                              // [RULE2] [RULE3]
        end
      end
      ST_RUN: begin
        if (stop_i) begin
          next_running = ST_IDLE;
        end
      end
      default: begin
        next_running = ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // Output registers
  // ****************************************
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      running_o            <= ST_IDLE;
      count_o              <= `CCD_CNT_RESET;
      counter_output_pin_o <= 1'b0;
    end else begin
      running_o            <= next_running;
      counter_output_pin_o <= next_pulse;                                     // [RULE1]
      if (running_o == ST_IDLE) begin
        if (start_i) begin
          count_o <= start_value;                                             // [RULE7]
        end
      end else begin
        count_o <= next_count;
      end
    end
  end

endmodule // ccd_counter_clock_divider

// *** common/ccd_defines.vh ***
// Constants for the counter clock divider: mode codes, reset values, widths.
// Assumes inclusion by bare name from the design file.
`ifndef CCD_DEFINES_VH
`define CCD_DEFINES_VH

// ****************************************
// Mode encodings
// ****************************************
`define CCD_GATE_SOFT       1'b0
`define CCD_GATE_LEVEL      1'b1
`define CCD_DIRSRC_SOFT     1'b0
`define CCD_DIRSRC_PIN      1'b1
`define CCD_DIR_DOWN        1'b0
`define CCD_DIR_UP          1'b1

// ****************************************
// Widths and reset values
// ****************************************
`define CCD_DIV_W           32
`define CCD_TB_W            32
`define CCD_DIV_RESET       32'h0003a980
`define CCD_CNT_RESET       32'h00000000

// ****************************************
// Run state codes
// ****************************************
`define CCD_ST_IDLE         1'b0
`define CCD_ST_RUN          1'b1

`endif

// *** sim/ccd_src.sv ***
// Far-side model: count clock pin, toggled each cycle while enabled.
// Assumes ref_clk_i is the divider's clock; rests low so no stale edge leaks.
`timescale 1ns/1ps
module ccd_src(input wire ref_clk_i, input wire on_i, output reg pin_o);
  initial pin_o = 1'b0;
  always @(posedge ref_clk_i) pin_o <= #1 (on_i ? ~pin_o : 1'b0);
endmodule // ccd_src

// *** sim/ccd_sva.sv ***
// Port checker for the clock divider.
// Assumes bind onto ccd_counter_clock_divider by port name.
`timescale 1ns/1ps
module ccd_sva(input wire ref_clk_i, reset_i, start_i, stop_i, gate_mode_i, gate_i, dir_source_i, dir_soft_i,
  direction_pin_i, ext_count_clock_pin_i, counter_output_pin_o, running_o,
  input wire [31:0] timebase_period_i, divisor_i, count_o);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  reg  pv;
  wire q  = counter_output_pin_o;
  wire up = dir_source_i ? direction_pin_i : dir_soft_i;
  // Counted pin edge, as seen in the same cycle
  wire ed = running_o & ext_count_clock_pin_i & ~pv & ~|timebase_period_i & (~gate_mode_i | gate_i) & ~stop_i;
  always @(posedge ref_clk_i) pv <= ext_count_clock_pin_i;
  property p_pls; q |=> !q; endproperty
  a_pls: assert property (p_pls) else $error("long pulse");
  property p_rld; q && !up |-> count_o == divisor_i; endproperty
  a_rld: assert property (p_rld) else $error("no reload");
  property p_st; start_i && !running_o |=> running_o && count_o == (up ? 1 : divisor_i); endproperty
  a_st: assert property (p_st) else $error("start lost");
  property p_gt; running_o && gate_mode_i && !gate_i && !stop_i |=> $stable(count_o); endproperty
  a_gt: assert property (p_gt) else $error("gate ignored");
  property p_dn; ed && !up && count_o > 1 |=> count_o == $past(count_o) - 1; endproperty
  a_dn: assert property (p_dn) else $error("bad decrement");
  property p_up; ed && up && count_o < divisor_i |=> count_o == $past(count_o) + 1; endproperty
  a_up: assert property (p_up) else $error("bad increment");
  property p_ext; running_o && !ed && ~|timebase_period_i && !stop_i |=> $stable(count_o); endproperty
  a_ext: assert property (p_ext) else $error("count without edge");
  property p_tc; ed && !up && count_o == 1 |=> q; endproperty
  a_tc: assert property (p_tc) else $error("no output pulse");
  property p_sp; running_o && stop_i |=> !running_o; endproperty
  a_sp: assert property (p_sp) else $error("stop lost");
  c_dn: cover property (q && !up);
  c_up: cover property (q && up);
  c_gt: cover property (running_o && gate_mode_i && !gate_i);
endmodule // ccd_sva

// *** sim/ccd_counter_clock_divider_bench.sv ***
// Self-checking bench for the clock divider.
// Assumes ccd_src drives the count clock pin.
`timescale 1ns/1ps
module ccd_counter_clock_divider_bench;
  reg clk = 0, rst = 1, st = 0, sp = 0, gm = 0, g = 0, ds = 0, dw = 0, dp = 0, on = 0, pv = 0;
  reg [31:0] tb = 0, dv = 3;
  wire pin, q, run;
  wire [31:0] cnt;
  int bad_count = 0, n_checks = 0, np = 0, ep = 0, gap = 0, cy = 0, edges = 0;
  initial forever #2 clk = ~clk;
  ccd_counter_clock_divider i_dut(.ref_clk_i(clk), .reset_i(rst), .start_i(st), .stop_i(sp), .gate_mode_i(gm),
    .gate_i(g), .dir_source_i(ds), .dir_soft_i(dw), .direction_pin_i(dp), .timebase_period_i(tb),
    .divisor_i(dv), .ext_count_clock_pin_i(pin), .counter_output_pin_o(q), .running_o(run), .count_o(cnt));
  ccd_src i_src(.ref_clk_i(clk), .on_i(on), .pin_o(pin));
  always @(posedge clk) begin
    pv <= pin;
    if (pin & ~pv) edges++;
    if (q === 1'b1) begin np++; ep = edges; gap = cy; cy = 1; end else cy++;
  end
  task tk; @(posedge clk) #1; endtask
  task chk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin bad_count++; $display("unexpected %0t %s", $time, m); end
  endtask
  // Stop first so a new divisor always loads cleanly
  task go(input [31:0] d, input [31:0] t);
    sp = 1; tk; sp = 0; dv = d; tb = t; st = 1; tk; st = 0; on = 1; np = 0; edges = 0;
  endtask
  task wp(input int n); repeat (400) if (np < n) tk; on = 0; chk(np === n, "missing pulses"); endtask
  task t_down; go(3, 0); wp(4); chk(ep === 12, "edge count"); chk(gap === 6, "rate"); endtask
  task t_up; ds = 1; dp = 1; go(5, 0); wp(2); chk(ep === 10, "up count"); chk(gap === 10, "up rate"); endtask
  task t_tb; ds = 0; dw = 1; go(3, 4); wp(2); chk(gap === 12, "timebase rate"); endtask
  task t_gate;
    dw = 0; gm = 1; go(3, 0); repeat (20) tk;
    chk(np === 0 && cnt === 3, "gate low counted");
    g = 1; wp(2); chk(gap === 6, "gated rate");
  endtask
  task end_sim;
    $display("checks %0d bad %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("[ PASS ]"); else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1 rst = 0;
    t_down; t_up; t_tb; t_gate;
    end_sim;
  end
  initial begin #40000; bad_count++; end_sim; end
endmodule // ccd_counter_clock_divider_bench
bind ccd_counter_clock_divider ccd_sva i_sva(.*);
